// ---- rtl/indirect_ram_access_port.sv ----
// host registers and indirect access to scratch, eq file, microprogram
module indirect_ram_access_port (
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic              sym_tick,
    input  iram_pkg::host_req_t    host_req,
    output logic [7:0]             host_rdata,
    output logic                   host_rvalid,
    output logic                   xfer_busy
);
    import iram_pkg::*;

    // host bus: synchronous to sys_clk, one cycle per access
    // reads answer one cycle later with host_rvalid
    // xfer_busy: a pointer write waits for its strobe
    // memories are not reset; reading one unwritten
    // turns the data word unknown
    // eq indices 48 to 63 read zero and drop writes
    // bytes written while a write transfer waits are
    // the bytes that it stores
    // pointer bits 7:6 are dropped on write, read as zero

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // all registers in one struct, one comb and one ff
    typedef struct packed {
        logic [PTR_W-1:0] scratch_read_pointer;
        logic [PTR_W-1:0] scratch_write_pointer;
        logic [PTR_W-1:0] eq_file_read_pointer;
        logic [PTR_W-1:0] eq_file_write_pointer;
        logic [PTR_W-1:0] microprogram_read_pointer;
        logic [PTR_W-1:0] microprogram_write_pointer;
        logic [31:0]      indirect_data_word;
        logic [7:0]       rdata;
        logic             rvalid;
        logic             busy;
    } port_state_t;

    port_state_t st;       // registered state
    port_state_t next_st;  // next value

    // wiring between decode, sequencer and memories
    xfer_req_t            req;          // start pulse to sequencer
    xfer_req_t            fire;         // execute pulse
    logic                 seq_busy;     // transfer waiting

    logic [SCRATCH_W-1:0] scratch_rd;   // scratch read data
    logic [EQ_FILE_W-1:0] eq_rd;        // eq file read data
    logic [MICRO_W-1:0]   micro_rd;     // microprogram read data

    logic                 scratch_we;   // scratch write
    logic                 eq_we;        // eq file write
    logic                 micro_we;     // microprogram write

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // shared by the read mux
    // pads a pointer into a readable byte, bits 7:6 zero
    function automatic logic [7:0] ptr_byte(input logic [PTR_W-1:0] p);
        return {2'b00, p};
    endfunction

    // picks byte n of the data word, low byte first
    function automatic logic [7:0] word_byte(input logic [31:0] w,
                                             input logic [1:0]  n);
        return w[8*n +: 8];
    endfunction

    // ------------------------------------------------------------
    // host write decode to transfer start
    // ------------------------------------------------------------
    // a write to a pointer offset starts a transfer; the
    // pointer byte rides along to the sequencer
    // anything else decodes to no request
    always_comb
    begin
        req = '{valid: 1'b0, kind: XFER_SCRATCH_RD,
                addr: host_req.wdata[PTR_W-1:0]};
        // reads never start a transfer
        if (host_req.wr)
        begin
            req.valid = 1'b1;
            unique case (host_req.addr)
                SCRATCH_READ_POINTER_OFS:       req.kind = XFER_SCRATCH_RD;
                SCRATCH_WRITE_POINTER_OFS:      req.kind = XFER_SCRATCH_WR;
                EQ_FILE_READ_POINTER_OFS:       req.kind = XFER_EQ_RD;
                EQ_FILE_WRITE_POINTER_OFS:      req.kind = XFER_EQ_WR;
                MICROPROGRAM_READ_POINTER_OFS:  req.kind = XFER_MICRO_RD;
                MICROPROGRAM_WRITE_POINTER_OFS: req.kind = XFER_MICRO_WR;
                default:                        req.valid = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // transfer sequencer and memories
    // ------------------------------------------------------------
    // completes at the next symbol strobe, inside two symbols
    // the hold takes the first strobe after the write, so
    // the worst case is one symbol and two cycles
    // a newer pointer write before it replaces the first
    // busy from the sequencer is the waiting flag
    iram_xfer_seq u_seq (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .sym_tick (sym_tick),
        .req      (req),
        .fire     (fire),
        .busy     (seq_busy)
    );

    // a read kind only selects the array for the data word
    // the execute pulse lasts exactly one cycle
    // write enables from the execute pulse; reads write nothing
    assign scratch_we = fire.valid && fire.kind == XFER_SCRATCH_WR;
    assign eq_we      = fire.valid && fire.kind == XFER_EQ_WR;
    assign micro_we   = fire.valid && fire.kind == XFER_MICRO_WR;

    // ------------------------------------------------------------
    // memories
    // ------------------------------------------------------------
    // the arrays share the execute address and read
    // combinationally; results land one edge later
    // entries past an array's depth read zero
    // scratch pad, 64 bytes
    iram_array #(
        .WIDTH  (SCRATCH_W),
        .DEPTH  (SCRATCH_DEPTH),
        .ADDR_W (PTR_W)
    ) u_scratch (
        .sys_clk (sys_clk),
        .wr_en   (scratch_we),
        .wr_addr (fire.addr),
        .wr_data (st.indirect_data_word[SCRATCH_W-1:0]),
        .rd_addr (fire.addr),
        .rd_data (scratch_rd)
    );

    // eq register file: coefficients and taps 0..25, gain and error signals
    // 26..34, 35..47 reserved but still storage
    iram_array #(
        .WIDTH  (EQ_FILE_W),
        .DEPTH  (EQ_FILE_DEPTH),
        .ADDR_W (PTR_W)
    ) u_eq_file (
        .sys_clk (sys_clk),
        .wr_en   (eq_we),
        .wr_addr (fire.addr),
        .wr_data (st.indirect_data_word[EQ_FILE_W-1:0]),
        .rd_addr (fire.addr),
        .rd_data (eq_rd)
    );

    // microprogram store, 64 words
    iram_array #(
        .WIDTH  (MICRO_W),
        .DEPTH  (MICRO_DEPTH),
        .ADDR_W (PTR_W)
    ) u_micro (
        .sys_clk (sys_clk),
        .wr_en   (micro_we),
        .wr_addr (fire.addr),
        .wr_data (st.indirect_data_word),
        .rd_addr (fire.addr),
        .rd_data (micro_rd)
    );

    // ------------------------------------------------------------
    // next state: host accesses and transfer results
    // ------------------------------------------------------------
    // a read transfer result overrides a host byte write
    // in the same cycle; host reads see the old word
    // pointer writes store bits 5:0 only
    always_comb
    begin
        next_st = st;
        next_st.rvalid = 1'b0;
        // busy follows the sequencer's next hold flag
        next_st.busy = (seq_busy && !sym_tick) || req.valid;
        // host writes store the pointer and data bytes
        if (host_req.wr)
        begin
            unique case (host_req.addr)
                SCRATCH_READ_POINTER_OFS:
                    next_st.scratch_read_pointer =
                        host_req.wdata[PTR_W-1:0];
                SCRATCH_WRITE_POINTER_OFS:
                    next_st.scratch_write_pointer =
                        host_req.wdata[PTR_W-1:0];
                EQ_FILE_READ_POINTER_OFS:
                    next_st.eq_file_read_pointer =
                        host_req.wdata[PTR_W-1:0];
                EQ_FILE_WRITE_POINTER_OFS:
                    next_st.eq_file_write_pointer =
                        host_req.wdata[PTR_W-1:0];
                MICROPROGRAM_READ_POINTER_OFS:
                    next_st.microprogram_read_pointer =
                        host_req.wdata[PTR_W-1:0];
                MICROPROGRAM_WRITE_POINTER_OFS:
                    next_st.microprogram_write_pointer =
                        host_req.wdata[PTR_W-1:0];
                default:
                begin
                    // offsets 0x7C to 0x7F are byte lanes 0 to 3
                    // data word byte lanes, low byte lowest
                    if (host_req.addr >= INDIRECT_DATA_WORD_OFS &&
                        host_req.addr <= INDIRECT_DATA_WORD_LAST_OFS)
                        next_st.indirect_data_word
                            [8*host_req.addr[1:0] +: 8] =
                            host_req.wdata;
                end
            endcase
        end

        // read transfers load the data word; writes leave it alone
        // a write kind leaves the data word as it is
        if (fire.valid)
        begin
            unique case (fire.kind)
                // upper bytes cleared for narrow reads
                XFER_SCRATCH_RD:
                    next_st.indirect_data_word =
                        {24'h00_0000, scratch_rd};
                XFER_EQ_RD:
                    next_st.indirect_data_word =
                        {16'h0000, eq_rd};
                XFER_MICRO_RD:
                    next_st.indirect_data_word = micro_rd;
                default:
                    next_st.indirect_data_word =
                        next_st.indirect_data_word;
            endcase
        end

        // host reads answer one cycle later; unmapped reads zero
        // pointer reads pad bits 7:6 and start nothing
        if (host_req.rd)
        begin
            next_st.rvalid = 1'b1;
            unique case (host_req.addr)
                SCRATCH_READ_POINTER_OFS:
                    next_st.rdata = ptr_byte(st.scratch_read_pointer);
                SCRATCH_WRITE_POINTER_OFS:
                    next_st.rdata = ptr_byte(st.scratch_write_pointer);
                EQ_FILE_READ_POINTER_OFS:
                    next_st.rdata = ptr_byte(st.eq_file_read_pointer);
                EQ_FILE_WRITE_POINTER_OFS:
                    next_st.rdata = ptr_byte(st.eq_file_write_pointer);
                MICROPROGRAM_READ_POINTER_OFS:
                    next_st.rdata =
                        ptr_byte(st.microprogram_read_pointer);
                MICROPROGRAM_WRITE_POINTER_OFS:
                    next_st.rdata =
                        ptr_byte(st.microprogram_write_pointer);
                default:
                begin
                    if (host_req.addr >= INDIRECT_DATA_WORD_OFS &&
                        host_req.addr <= INDIRECT_DATA_WORD_LAST_OFS)
                        next_st.rdata = word_byte(st.indirect_data_word,
                                                  host_req.addr[1:0]);
                    else
                        next_st.rdata = BYTE_RESET;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // reset clears the struct; memory contents stay
    // a request may follow on the first edge after it
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            st <= '{scratch_read_pointer:       PTR_RESET,
                    scratch_write_pointer:      PTR_RESET,
                    eq_file_read_pointer:       PTR_RESET,
                    eq_file_write_pointer:      PTR_RESET,
                    microprogram_read_pointer:  PTR_RESET,
                    microprogram_write_pointer: PTR_RESET,
                    indirect_data_word:         WORD_RESET,
                    rdata:                      BYTE_RESET,
                    rvalid:                     1'b0,
                    busy:                       1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

    // no combinational path reaches the host side
    // host_rdata holds until the next read
    // outputs straight from the state register
    assign host_rdata  = st.rdata;
    assign host_rvalid = st.rvalid;
    assign xfer_busy   = st.busy;

endmodule

// ---- rtl/iram_pkg.sv ----
// constants and types of the indirect ram access port
package iram_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] SCRATCH_READ_POINTER_OFS       = 8'h76;
    localparam logic [7:0] SCRATCH_WRITE_POINTER_OFS      = 8'h77;
    localparam logic [7:0] EQ_FILE_READ_POINTER_OFS       = 8'h78;
    localparam logic [7:0] EQ_FILE_WRITE_POINTER_OFS      = 8'h79;
    localparam logic [7:0] MICROPROGRAM_READ_POINTER_OFS  = 8'h7A;
    localparam logic [7:0] MICROPROGRAM_WRITE_POINTER_OFS = 8'h7B;
    localparam logic [7:0] INDIRECT_DATA_WORD_OFS         = 8'h7C;
    localparam logic [7:0] INDIRECT_DATA_WORD_LAST_OFS    = 8'h7F;

    // ------------------------------------------------------------
    // widths and depths
    // ------------------------------------------------------------
    localparam int PTR_W          = 6;
    localparam int SCRATCH_W      = 8;
    localparam int SCRATCH_DEPTH  = 64;
    localparam int EQ_FILE_W      = 16;
    localparam int EQ_FILE_DEPTH  = 48;
    localparam int MICRO_W        = 32;
    localparam int MICRO_DEPTH    = 64;

    // ------------------------------------------------------------
    // eq file layout (entry indices)
    // ------------------------------------------------------------
    localparam logic [5:0] EQ_FF_COEF_FIRST   = 6'h00;
    localparam logic [5:0] EQ_FF_TAP_FIRST    = 6'h08;
    localparam logic [5:0] EQ_EP_COEF_FIRST   = 6'h10;
    localparam logic [5:0] EQ_EP_TAP_FIRST    = 6'h15;
    localparam logic [5:0] EQ_GAIN_LOW        = 6'h1A;
    localparam logic [5:0] EQ_GAIN_HIGH       = 6'h1B;
    localparam logic [5:0] EQ_GAIN_OUT        = 6'h1C;
    localparam logic [5:0] EQ_FF_OUT          = 6'h1D;
    localparam logic [5:0] EQ_GAIN_IN         = 6'h1E;
    localparam logic [5:0] EQ_FF_OUT_DELAYED  = 6'h1F;
    localparam logic [5:0] EQ_GAIN_ERR        = 6'h20;
    localparam logic [5:0] EQ_EQ_ERR          = 6'h21;
    localparam logic [5:0] EQ_SLICER_ERR      = 6'h22;
    localparam logic [5:0] EQ_RESERVED_FIRST  = 6'h23;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [5:0]  PTR_RESET  = 6'h00;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam logic [7:0]  BYTE_RESET = 8'h00;

    // ------------------------------------------------------------
    // transfer kinds, one-hot
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        XFER_SCRATCH_RD = 6'b000001,
        XFER_SCRATCH_WR = 6'b000010,
        XFER_EQ_RD      = 6'b000100,
        XFER_EQ_WR      = 6'b001000,
        XFER_MICRO_RD   = 6'b010000,
        XFER_MICRO_WR   = 6'b100000
    } xfer_kind_t;

    // host register access, one cycle per access
    typedef struct packed {
        logic       wr;    // write strobe
        logic       rd;    // read strobe
        logic [7:0] addr;  // register offset
        logic [7:0] wdata; // write byte
    } host_req_t;

    // transfer request from decode to sequencer
    typedef struct packed {
        logic             valid; // start pulse
        xfer_kind_t       kind;  // which transfer
        logic [PTR_W-1:0] addr;  // memory index
    } xfer_req_t;

endpackage

// ---- rtl/iram_array.sv ----
// generic word memory with combinational read and clocked write
module iram_array #(
    parameter int WIDTH  = 8,
    parameter int DEPTH  = 64,
    parameter int ADDR_W = 6
) (
    input  wire logic              sys_clk,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]  wr_data,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [WIDTH-1:0]  rd_data
);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (DEPTH < 1 || DEPTH > (1 << ADDR_W))
    begin : g_bad_depth
        $error("iram_array depth does not fit address width");
    end

    logic [WIDTH-1:0] mem [DEPTH]; // storage words

    // read: indices past the last entry answer zero
    always_comb
    begin
        if (32'(rd_addr) < DEPTH)
            rd_data = mem[rd_addr];
        else
            rd_data = '0;
    end

    // write: only on an explicit write, ignored past the end
    always_ff @(posedge sys_clk)
    begin
        if (wr_en && 32'(wr_addr) < DEPTH)
            mem[wr_addr] <= wr_data;
    end

endmodule

// ---- rtl/iram_xfer_seq.sv ----
// holds a requested transfer until the next symbol strobe
module iram_xfer_seq (
    input  wire logic                  sys_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  sym_tick,
    input  iram_pkg::xfer_req_t        req,
    output iram_pkg::xfer_req_t        fire,
    output logic                       busy
);
    import iram_pkg::*;

    // sequencer state
    typedef struct packed {
        logic      pending; // request waiting for strobe
        xfer_req_t held;    // waiting request
        xfer_req_t fire;    // one-cycle execute pulse
    } seq_state_t;

    seq_state_t st;
    seq_state_t next_st;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        next_st.fire.valid = 1'b0;
        // execute at the first strobe seen after capture
        if (st.pending && sym_tick)
        begin
            next_st.fire = st.held;
            next_st.fire.valid = 1'b1;
            next_st.pending = 1'b0;
        end
        // a newer pointer write replaces a waiting one unless this cycle's strobe fires it
        if (req.valid)
        begin
            next_st.held = req;
            next_st.pending = 1'b1;
        end
    end

    // state register
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            st <= '{pending: 1'b0,
                    held: '{valid: 1'b0, kind: XFER_SCRATCH_RD,
                            addr: PTR_RESET},
                    fire: '{valid: 1'b0, kind: XFER_SCRATCH_RD,
                            addr: PTR_RESET}};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign fire = st.fire;
    assign busy = st.pending;

endmodule

// ---- bench/iram_port_props.sv ----
// port checks of the indirect ram access port
module iram_port_props
    import iram_pkg::*;
(
    input  wire logic          sys_clk,
    input  wire logic          sys_rst,
    input  wire logic          sym_tick,
    input  iram_pkg::host_req_t host_req,
    input  wire logic [7:0]    host_rdata,
    input  wire logic          host_rvalid,
    input  wire logic          xfer_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // decode of host accesses
    // ------------------------------------------------------------
    logic in_ptr; // offset is one of the six pointers
    logic ptr_wr; // host write to a pointer
    logic ptr_rd; // host read of a pointer
    assign in_ptr = host_req.addr >= SCRATCH_READ_POINTER_OFS
        && host_req.addr <= MICROPROGRAM_WRITE_POINTER_OFS;
    assign ptr_wr = host_req.wr && in_ptr;
    assign ptr_rd = host_req.rd && in_ptr;

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_ptr_starts_busy: assert property (ptr_wr |=> xfer_busy)
        else $error("busy did not rise after a pointer write");
    a_busy_has_cause: assert property (
        $rose(xfer_busy) |-> $past(ptr_wr))
        else $error("busy rose without a pointer write");
    a_busy_waits_tick: assert property (
        xfer_busy && !sym_tick && !ptr_wr |=> xfer_busy)
        else $error("transfer ended without a symbol strobe");
    a_busy_ends_tick: assert property (
        xfer_busy && sym_tick && !ptr_wr |=> !xfer_busy)
        else $error("transfer not done after a symbol strobe");
    a_read_answers: assert property (host_req.rd |=> host_rvalid)
        else $error("read not answered in one cycle");
    a_rvalid_cause: assert property (
        host_rvalid |-> $past(host_req.rd))
        else $error("read valid without a read");
    a_rdata_holds: assert property (
        !host_rvalid |-> $stable(host_rdata))
        else $error("read byte changed without a read");
    a_ptr_upper_zero: assert property (
        ptr_rd |=> host_rdata[7:6] == 2'b00)
        else $error("pointer upper bits not zero");
endmodule

bind indirect_ram_access_port iram_port_props chk (
    .sys_clk     (sys_clk),
    .sys_rst     (sys_rst),
    .sym_tick    (sym_tick),
    .host_req    (host_req),
    .host_rdata  (host_rdata),
    .host_rvalid (host_rvalid),
    .xfer_busy   (xfer_busy)
);

// ---- bench/iram_host_model.sv ----
// host side model: one-cycle register reads and writes
module iram_host_model
    import iram_pkg::*;
(
    input  wire logic          sys_clk,
    output iram_pkg::host_req_t host_req,
    input  wire logic [7:0]    host_rdata,
    input  wire logic          host_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;

    // bus idle at time zero
    initial host_req = '0;

    // one access: strobe for one edge, then release with scrambled lines
    task automatic put(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge sys_clk);
        host_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge sys_clk);
        host_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        #1;
    endtask

    // register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        put(1'b1, a, d);
    endtask

    // register read, answer taken in the cycle it stands
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic v);
        put(1'b0, a, 8'($urandom));
        d = host_rdata;
        v = host_rvalid;
    endtask
endmodule

// ---- bench/tb.sv ----
// self-checking bench of the indirect ram access port
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import iram_pkg::*;

    // ------------------------------------------------------------
    // signals and model state
    // ------------------------------------------------------------
    localparam int SYM_PER = 6;      // clocks per symbol
    logic            sys_clk;        // system clock
    logic            sys_rst;        // synchronous reset
    logic            sym_tick;       // symbol strobe
    host_req_t       host_req;       // host request from the model
    logic [7:0]      host_rdata;     // read answer
    logic            host_rvalid;    // read answer valid
    logic            xfer_busy;      // transfer pending
    int              tcnt = 0;       // symbol phase
    int              err_count = 0;  // mismatches
    int              num_checks = 0; // comparisons
    logic [31:0]     mdl [3][64];    // memory model per kind
    bit              known [3][64];  // entry written with known data
    logic [31:0]     dw = '0;        // data word model
    bit              dw_known = 1;   // data word model valid

    indirect_ram_access_port dut (
        .sys_clk     (sys_clk),
        .sys_rst     (sys_rst),
        .sym_tick    (sym_tick),
        .host_req    (host_req),
        .host_rdata  (host_rdata),
        .host_rvalid (host_rvalid),
        .xfer_busy   (xfer_busy)
    );

    iram_host_model host (
        .sys_clk     (sys_clk),
        .host_req    (host_req),
        .host_rdata  (host_rdata),
        .host_rvalid (host_rvalid)
    );

    // clock and periodic symbol strobe
    initial
    begin
        sys_clk = 0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial sym_tick = 0;
    always @(posedge sys_clk)
    begin
        tcnt <= (tcnt == SYM_PER - 1) ? 0 : tcnt + 1;
        sym_tick <= (tcnt == SYM_PER - 1);
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        if (err_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // one comparison
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // fill the data word byte by byte
    task automatic set_word(input logic [31:0] w);
        for (int i = 0; i < 4; i++)
            host.wr(INDIRECT_DATA_WORD_OFS + 8'(i), w[8*i +: 8]);
        dw = w;
        dw_known = 1;
    endtask

    // read the data word, low byte at the lowest offset
    task automatic read_word(output logic [31:0] w);
        logic [7:0] b;
        logic       v;
        for (int i = 0; i < 4; i++)
        begin
            host.rd(INDIRECT_DATA_WORD_OFS + 8'(i), b, v);
            chk("read valid", 32'h1, 32'(v));
            w[8*i +: 8] = b;
        end
    endtask

    // one indirect transfer, then word and pointer readback
    task automatic xfer(int m, bit st, int idx);
        logic [7:0]  p;
        logic [7:0]  ofs;
        logic [7:0]  b;
        logic        v;
        logic [31:0] w;
        logic [31:0] mask;
        int          n;
        p = {2'($urandom_range(0, 3)), 6'(idx)};
        ofs = SCRATCH_READ_POINTER_OFS + 8'(2 * m + st);
        mask = m == 0 ? 32'h0000_00FF : m == 1 ? 32'h0000_FFFF : '1;
        host.wr(ofs, p);
        n = 0;
        while (xfer_busy !== 1'b0 && n < 40)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk("transfer time", 32'h1, 32'(n <= 2 * SYM_PER));
        if (m == 1 && idx >= EQ_FILE_DEPTH)
        begin
            // eq indices past the file: store ignored, load gives zero
            if (!st)
                dw = '0;
            dw_known = dw_known || !st;
        end
        else if (st)
        begin
            mdl[m][idx] = dw & mask;
            known[m][idx] = dw_known;
        end
        else
        begin
            dw = mdl[m][idx];
            dw_known = known[m][idx];
        end
        read_word(w);
        if (!dw_known)
            ;
        else if (st)
            chk("word kept", dw, w);
        else if (m == 0)
            chk("scratch load", dw, w);
        else if (m == 1)
            chk("eq load", dw, w);
        else
            chk("micro load", dw, w);
        host.rd(ofs, b, v);
        chk("pointer", 32'(p[5:0]), 32'(b));
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        logic [7:0]  b;
        logic        v;
        logic [31:0] w;
        int          m;
        int          r;
        sys_rst = 1;
        repeat (10) @(posedge sys_clk);
        sys_rst <= 0;
        void'($urandom(24));
        // reset values, unmapped places around the block read zero
        host.wr(8'h75, 8'($urandom));
        for (int a = 8'h74; a <= 8'h80; a++)
        begin
            host.rd(8'(a), b, v);
            chk("reset value", 32'h0, 32'(b));
        end
        set_word($urandom);
        read_word(w);
        chk("word bytes", dw, w);
        // random mix of transfers with boundary indices
        for (int k = 0; k < 150; k++)
        begin
            m = $urandom_range(0, 2);
            r = $urandom_range(0, 5);
            r = r == 0 ? 0 : r == 1 ? 63 : r == 2 ? 47 : $urandom_range(0, 7);
            if (k % 2 == 0)
                set_word($urandom);
            xfer(m, k % 2 == 0, r);
        end
        give_verdict();
    end

    initial
    begin
        repeat (60000) @(posedge sys_clk);
        err_count++;
        give_verdict();
    end
endmodule
